// [dnfe_pkg.sv]
package dnfe_pkg;

  // ==========================================================================
  // APB register map (byte addresses).
  localparam logic [7:0] ADDR_CFG_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_CUR_IP    = 8'h08;
  localparam logic [7:0] ADDR_NV_IP     = 8'h0C;
  localparam logic [7:0] ADDR_NV_MASK   = 8'h10;
  localparam logic [7:0] ADDR_NV_GW     = 8'h14;
  localparam logic [7:0] ADDR_EXP_CTRL  = 8'h18;
  localparam logic [7:0] ADDR_EXP_TGT   = 8'h1C;
  localparam logic [7:0] ADDR_ACT_IP    = 8'h20;
  localparam logic [7:0] ADDR_ACT_MASK  = 8'h24;
  localparam logic [7:0] ADDR_ACT_GW    = 8'h28;
  localparam logic [7:0] ADDR_MOTION    = 8'h2C;

  // ==========================================================================
  // Address switch codes and configuration-control values.
  localparam logic [6:0] SW_DHCP        = 7'h63;
  localparam logic [6:0] SW_BOOTP       = 7'h62;
  localparam logic [6:0] SW_STORED      = 7'h61;
  localparam logic [6:0] SW_FIX_MAX     = 7'h60;
  localparam logic [6:0] SW_USE_CFG     = 7'h00;
  localparam logic [1:0] CC_STORED      = 2'h0;
  localparam logic [1:0] CC_BOOTP       = 2'h1;
  localparam logic [1:0] CC_DHCP        = 2'h2;
  localparam logic [1:0] CC_RESET       = CC_DHCP;
  localparam logic [31:0] FIX_IP_BASE   = 32'hC0A80100;
  localparam logic [31:0] FIX_MASK      = 32'hFFFFFF00;
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;

  // ==========================================================================
  // Control word bits.
  localparam int CW_MAN_FWD   = 0;
  localparam int CW_MAN_REV   = 1;
  localparam int CW_STROBE    = 2;
  localparam int CW_RELEASE   = 4;

  // ==========================================================================
  // Indicator timing.
  localparam int CLK_HZ        = 100_000_000;
  localparam int ACT_HZ        = 10;
  localparam int FLASH_HZ      = 1;
  localparam int MOTOR_HZ_X10  = 5;
  localparam int ACT_HALF      = CLK_HZ / (2 * ACT_HZ);
  localparam int FLASH_HALF    = CLK_HZ / (2 * FLASH_HZ);
  localparam int MOTOR_HALF    = (CLK_HZ * 10) / (2 * MOTOR_HZ_X10);

  typedef enum logic [1:0] {
    DNFE_SRC_STORED = 2'h0,
    DNFE_SRC_BOOTP  = 2'h1,
    DNFE_SRC_DHCP   = 2'h2,
    DNFE_SRC_FIXED  = 2'h3
  } dnfe_src_e;

  typedef enum logic [1:0] {
    DNFE_IDLE   = 2'b00,
    DNFE_POSRUN = 2'b01,
    DNFE_MANRUN = 2'b11
  } dnfe_run_e;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] target;
  } dnfe_cmd_s;

  typedef struct packed {
    logic red;
    logic green;
  } dnfe_led_s;

endpackage : dnfe_pkg

// [dnfe_scanner.sv]
`timescale 1ns/10ps
// ==========================================================================
// Scanner model: owns the cyclic connection and sends one-cycle frames.
module dnfe_scanner
  import dnfe_pkg::*;
(
  input  wire logic clk,
  output logic      valid,
  output dnfe_cmd_s cmd,
  output logic      conn
);
  // Idle at time zero; no frame is offered before the bench asks.
  initial begin
    valid = 1'b0;
    cmd   = '0;
    conn  = 1'b0;
  end
  // The connection settles for three edges because the block synchronises it.
  task automatic link(input logic on);
    @(posedge clk);
    conn <= on;
    repeat (3) @(posedge clk);
  endtask : link
  // Payload is inverted after the frame so a stale value never looks valid.
  task automatic send(input logic [15:0] ctrl, input logic [31:0] tgt);
    @(posedge clk);
    valid <= 1'b1;
    cmd   <= '{ctrl: ctrl, target: tgt};
    @(posedge clk);
    valid <= 1'b0;
    cmd   <= ~cmd;
  endtask : send
endmodule : dnfe_scanner

// [dnfe_top.sv]
`timescale 1ns/10ps
module dnfe_top
  import dnfe_pkg::*;
#(
  parameter int ACT_HALF_CYC   = ACT_HALF,
  parameter int FLASH_HALF_CYC = FLASH_HALF,
  parameter int MOTOR_HALF_CYC = MOTOR_HALF,
  parameter int NPORTS         = 2
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [6:0]        addr_switch,
  input  wire logic              cyc_valid,
  input  wire dnfe_cmd_s         cyc_cmd,
  input  wire logic              cyc_conn_active,
  input  wire logic [NPORTS-1:0] link_up,
  input  wire logic [NPORTS-1:0] port_traffic,
  input  wire logic              self_test,
  input  wire logic              minor_fault,
  input  wire logic              major_fault,
  input  wire logic              conn_timeout,
  input  wire logic              dup_address,
  input  wire logic              motor_supply_ok,
  input  wire logic              factory_state,
  output logic [NPORTS-1:0]      port_link_led,
  output logic [NPORTS-1:0]      port_activity_indicator,
  output dnfe_led_s              module_health_indicator,
  output dnfe_led_s              network_health_indicator,
  output logic                   motor_led,
  output dnfe_src_e              ip_source,
  output logic                   nv_save_pulse,
  output logic                   nv_cfg_write_pulse,
  output dnfe_run_e              run_state,
  output logic [31:0]            run_target,
  output logic                   target_update
);

  if (NPORTS < 1 || ACT_HALF_CYC < 1 || FLASH_HALF_CYC < 1 || MOTOR_HALF_CYC < 1) begin : g_bad
    $error("dnfe_top: bad parameter");
  end

  // ==========================================================================
  // Input synchronisers; switch, link, traffic and status pins pass two flip-flops before use.
  localparam int SYNC_W = 7 + 2 * NPORTS + 8;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  wire  [SYNC_W-1:0] pins = {addr_switch, link_up, port_traffic, self_test, minor_fault,
                             major_fault, conn_timeout, dup_address, motor_supply_ok,
                             factory_state, cyc_conn_active};
  always_ff @(posedge core_clk) begin
    sync1_ff <= pins;
    sync2_ff <= sync1_ff;
  end
  wire [6:0]        sw_s     = sync2_ff[SYNC_W-1 -: 7];
  wire [NPORTS-1:0] link_s   = sync2_ff[8+NPORTS +: NPORTS];
  wire [NPORTS-1:0] traf_s   = sync2_ff[8 +: NPORTS];
  wire              test_s   = sync2_ff[7];
  wire              minor_s  = sync2_ff[6];
  wire              major_s  = sync2_ff[5];
  wire              tmo_s    = sync2_ff[4];
  wire              dup_s    = sync2_ff[3];
  wire              motok_s  = sync2_ff[2];
  wire              fact_s   = sync2_ff[1];
  wire              conn_s   = sync2_ff[0];

  // ==========================================================================
  // Registers reached over APB. Stored values stand in for the EEPROM image.
  logic [1:0]  cfg_ctrl_ff = CC_RESET;
  logic [31:0] nv_ip_ff = 32'h0;
  logic [31:0] nv_mask_ff = 32'h0;
  logic [31:0] nv_gw_ff = 32'h0;
  logic [31:0] cur_ip_ff;
  logic [15:0] exp_ctrl_ff;
  logic [31:0] exp_tgt_ff;
  logic [31:0] act_ip_ff;
  logic [31:0] act_mask_ff;
  logic [31:0] act_gw_ff;
  logic        sampled_ff;
  logic [6:0]  last_sw_ff;
  logic        exp_go_ff;

  // Zero-wait slave: every access completes in its first access cycle.
  wire wr_acc = psel & penable & pwrite;
  wire rd_hit = (paddr == ADDR_CFG_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_CUR_IP) |
                (paddr == ADDR_NV_IP) | (paddr == ADDR_NV_MASK) | (paddr == ADDR_NV_GW) |
                (paddr == ADDR_EXP_CTRL) | (paddr == ADDR_EXP_TGT) | (paddr == ADDR_ACT_IP) |
                (paddr == ADDR_ACT_MASK) | (paddr == ADDR_ACT_GW) | (paddr == ADDR_MOTION);
  wire wr_cfg = wr_acc & (paddr == ADDR_CFG_CTRL);
  wire wr_cur = wr_acc & (paddr == ADDR_CUR_IP);
  wire wr_nip = wr_acc & (paddr == ADDR_NV_IP);
  wire wr_nmk = wr_acc & (paddr == ADDR_NV_MASK);
  wire wr_ngw = wr_acc & (paddr == ADDR_NV_GW);
  // Explicit control-word writes are ignored while a cyclic connection runs.
  wire wr_ecw = wr_acc & (paddr == ADDR_EXP_CTRL) & ~conn_s;
  wire wr_etg = wr_acc & (paddr == ADDR_EXP_TGT) & ~conn_s;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;

  // Read data comes from a flop updated on the setup cycle.
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      ADDR_CFG_CTRL: rd_mux = {30'h0, cfg_ctrl_ff};
      ADDR_STATUS:   rd_mux = {27'h0, conn_s, ip_source, sampled_ff, major_s};
      ADDR_CUR_IP:   rd_mux = cur_ip_ff;
      ADDR_NV_IP:    rd_mux = nv_ip_ff;
      ADDR_NV_MASK:  rd_mux = nv_mask_ff;
      ADDR_NV_GW:    rd_mux = nv_gw_ff;
      ADDR_EXP_CTRL: rd_mux = {16'h0, exp_ctrl_ff};
      ADDR_EXP_TGT:  rd_mux = exp_tgt_ff;
      ADDR_ACT_IP:   rd_mux = act_ip_ff;
      ADDR_ACT_MASK: rd_mux = act_mask_ff;
      ADDR_ACT_GW:   rd_mux = act_gw_ff;
      ADDR_MOTION:   rd_mux = {30'h0, run_state};
      default:       rd_mux = ZERO_WORD;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (psel & ~penable) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================================
  // Address source, sampled once after reset release from the synced switches.
  wire sw_fixed = (sw_s != SW_USE_CFG) && (sw_s <= SW_FIX_MAX);
  dnfe_src_e src_pick;
  always_comb begin
    if (sw_s == SW_DHCP) begin
      src_pick = DNFE_SRC_DHCP;
    end else if (sw_s == SW_BOOTP) begin
      src_pick = DNFE_SRC_BOOTP;
    end else if (sw_s == SW_STORED) begin
      src_pick = DNFE_SRC_STORED;
    end else if (sw_fixed) begin
      src_pick = DNFE_SRC_FIXED;
    end else if (cfg_ctrl_ff == CC_BOOTP) begin
      src_pick = DNFE_SRC_BOOTP;
    end else if (cfg_ctrl_ff == CC_STORED) begin
      src_pick = DNFE_SRC_STORED;
    end else begin
      src_pick = DNFE_SRC_DHCP;
    end
  end

  // The sync chain needs two edges to fill, so sampling waits on a short delay.
  logic [1:0] boot_cnt_ff;
  wire        boot_take = (boot_cnt_ff == 2'h3) & ~sampled_ff;
  wire        sw_to_97  = sampled_ff & (sw_s == SW_STORED) & (last_sw_ff != SW_STORED);
  wire        save_now  = sw_to_97 | (wr_cfg & (pwdata[1:0] == CC_STORED));
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      boot_cnt_ff <= 2'h0;
      sampled_ff  <= 1'b0;
      ip_source   <= DNFE_SRC_DHCP;
      last_sw_ff  <= SW_USE_CFG;
      act_ip_ff   <= 32'h0;
      act_mask_ff <= 32'h0;
      act_gw_ff   <= 32'h0;
    end else begin
      boot_cnt_ff <= (boot_cnt_ff == 2'h3) ? boot_cnt_ff : boot_cnt_ff + 2'h1;
      last_sw_ff  <= sw_s;
      if (boot_take) begin
        sampled_ff <= 1'b1;
        ip_source  <= src_pick;
        if (src_pick == DNFE_SRC_FIXED) begin
          act_ip_ff   <= FIX_IP_BASE | {25'h0, sw_s};
          act_mask_ff <= FIX_MASK;
          act_gw_ff   <= ZERO_WORD;
        end else if (src_pick == DNFE_SRC_STORED) begin
          // A zero stored word is skipped and the field stays unset.
          if (nv_ip_ff != ZERO_WORD) act_ip_ff <= nv_ip_ff;
          if (nv_mask_ff != ZERO_WORD) act_mask_ff <= nv_mask_ff;
          if (nv_gw_ff != ZERO_WORD) act_gw_ff <= nv_gw_ff;
        end
      end
    end
  end

  // Stored image: kept through sys_rst, power-on values set at declaration.
  always_ff @(posedge core_clk) begin
    if (wr_cfg) cfg_ctrl_ff <= pwdata[1:0];
    if (save_now) begin
      nv_ip_ff <= cur_ip_ff;
    end else if (wr_nip) begin
      nv_ip_ff <= pwdata;
    end
    if (wr_nmk) nv_mask_ff <= pwdata;
    if (wr_ngw) nv_gw_ff <= pwdata;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cur_ip_ff          <= 32'h0;
      nv_save_pulse      <= 1'b0;
      nv_cfg_write_pulse <= 1'b0;
    end else begin
      if (wr_cur) cur_ip_ff <= pwdata;
      else if (boot_take & (src_pick == DNFE_SRC_FIXED)) cur_ip_ff <= FIX_IP_BASE | {25'h0, sw_s};
      nv_save_pulse      <= save_now;
      nv_cfg_write_pulse <= wr_cfg;
    end
  end

  // ==========================================================================
  // Command interpreter: one control word per cyclic frame or explicit write.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      exp_ctrl_ff <= 16'h0;
      exp_tgt_ff  <= 32'h0;
      exp_go_ff   <= 1'b0;
    end else begin
      if (wr_etg) exp_tgt_ff <= pwdata;
      if (wr_ecw) exp_ctrl_ff <= pwdata[15:0];
      exp_go_ff <= wr_ecw;
    end
  end
  wire        cyc_go  = cyc_valid & conn_s;
  wire        cmd_go  = cyc_go | exp_go_ff;
  wire [15:0] cw      = cyc_go ? cyc_cmd.ctrl : exp_ctrl_ff;
  wire [31:0] tgt     = cyc_go ? cyc_cmd.target : exp_tgt_ff;
  wire        rel     = cw[CW_RELEASE];
  // Explicit path has no strobe bit: its own write supplies the target.
  wire        tk_tgt  = cyc_go ? cw[CW_STROBE] : 1'b1;
  wire        man     = cw[CW_MAN_FWD] | cw[CW_MAN_REV];
  logic       pend_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run_state     <= DNFE_IDLE;
      run_target    <= 32'h0;
      target_update <= 1'b0;
      pend_ff       <= 1'b0;
    end else begin
      target_update <= 1'b0;
      if (cmd_go) begin
        if (tk_tgt & ~man) begin
          run_target    <= tgt;
          target_update <= 1'b1;
          pend_ff       <= 1'b1;
        end
        if (~rel) begin
          run_state <= DNFE_IDLE;
        end else if (man) begin
          run_state <= DNFE_MANRUN;
        end else if (tk_tgt | pend_ff) begin
          run_state <= DNFE_POSRUN;
          pend_ff   <= 1'b0;
        end else if (run_state == DNFE_MANRUN) begin
          run_state <= DNFE_IDLE;
        end else begin
          run_state <= run_state;
        end
      end
    end
  end

  // ==========================================================================
  // Blink timebases: one free counter per rate keeps the LEDs in step.
  logic [31:0] act_cnt_ff;
  logic [31:0] fl_cnt_ff;
  logic [31:0] mot_cnt_ff;
  logic        act_ph_ff;
  logic        fl_ph_ff;
  logic        mot_ph_ff;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      act_cnt_ff <= 32'h0;
      fl_cnt_ff  <= 32'h0;
      mot_cnt_ff <= 32'h0;
      act_ph_ff  <= 1'b0;
      fl_ph_ff   <= 1'b0;
      mot_ph_ff  <= 1'b0;
    end else begin
      act_cnt_ff <= (act_cnt_ff == 32'(ACT_HALF_CYC - 1)) ? 32'h0 : act_cnt_ff + 32'h1;
      fl_cnt_ff  <= (fl_cnt_ff == 32'(FLASH_HALF_CYC - 1)) ? 32'h0 : fl_cnt_ff + 32'h1;
      mot_cnt_ff <= (mot_cnt_ff == 32'(MOTOR_HALF_CYC - 1)) ? 32'h0 : mot_cnt_ff + 32'h1;
      if (act_cnt_ff == 32'(ACT_HALF_CYC - 1)) act_ph_ff <= ~act_ph_ff;
      if (fl_cnt_ff == 32'(FLASH_HALF_CYC - 1)) fl_ph_ff <= ~fl_ph_ff;
      if (mot_cnt_ff == 32'(MOTOR_HALF_CYC - 1)) mot_ph_ff <= ~mot_ph_ff;
    end
  end

  // ==========================================================================
  // Indicator decode; outputs are registered so they never glitch.
  wire have_ip = sampled_ff & (act_ip_ff != ZERO_WORD);
  dnfe_led_s ms_nxt;
  dnfe_led_s ns_nxt;
  always_comb begin
    if (test_s)           ms_nxt = '{red: fl_ph_ff, green: ~fl_ph_ff};
    else if (major_s)     ms_nxt = '{red: 1'b1, green: 1'b0};
    else if (minor_s)     ms_nxt = '{red: fl_ph_ff, green: 1'b0};
    else if (~have_ip)    ms_nxt = '{red: 1'b0, green: fl_ph_ff};
    else                  ms_nxt = '{red: 1'b0, green: 1'b1};
    if (test_s)           ns_nxt = '{red: fl_ph_ff, green: ~fl_ph_ff};
    else if (~have_ip)    ns_nxt = '{red: 1'b0, green: 1'b0};
    else if (dup_s)       ns_nxt = '{red: 1'b1, green: 1'b0};
    else if (tmo_s)       ns_nxt = '{red: fl_ph_ff, green: 1'b0};
    else if (~conn_s)     ns_nxt = '{red: 1'b0, green: fl_ph_ff};
    else                  ns_nxt = '{red: 1'b0, green: 1'b1};
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_link_led            <= '0;
      port_activity_indicator  <= '0;
      module_health_indicator  <= '0;
      network_health_indicator <= '0;
      motor_led                <= 1'b0;
    end else begin
      port_link_led            <= link_s;
      port_activity_indicator  <= link_s & traf_s & {NPORTS{act_ph_ff}};
      module_health_indicator  <= ms_nxt;
      network_health_indicator <= ns_nxt;
      motor_led                <= motok_s & (~fact_s | mot_ph_ff);
    end
  end

endmodule : dnfe_top

// [dnfe_top_props.sv]
`timescale 1ns/10ps
// ==========================================================================
// Checker on the top-level ports.
module dnfe_top_props
  import dnfe_pkg::*;
#(
  parameter int NPORTS = 2
) (
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic [7:0]        paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              cyc_valid,
  input wire dnfe_cmd_s         cyc_cmd,
  input wire logic              cyc_conn_active,
  input wire logic [NPORTS-1:0] link_up,
  input wire logic [NPORTS-1:0] port_traffic,
  input wire logic              self_test,
  input wire logic              major_fault,
  input wire logic              motor_supply_ok,
  input wire logic              factory_state,
  input wire logic [NPORTS-1:0] port_link_led,
  input wire logic [NPORTS-1:0] port_activity_indicator,
  input wire dnfe_led_s         module_health_indicator,
  input wire logic              motor_led,
  input wire logic              nv_save_pulse,
  input wire logic              nv_cfg_write_pulse,
  input wire dnfe_run_e         run_state,
  input wire logic [31:0]       run_target,
  input wire logic              target_update
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] conn_hist_ff;
  logic       conn_ok;
  logic       cfg_wr;
  // Connection history; a frame only counts once the synchroniser has settled.
  always_ff @(posedge core_clk) begin
    conn_hist_ff <= {conn_hist_ff[1:0], cyc_conn_active & ~sys_rst};
  end
  assign conn_ok = cyc_conn_active & (&conn_hist_ff);
  assign cfg_wr  = psel & penable & pwrite & (paddr == ADDR_CFG_CTRL);
  AST_CYC_POS: assert property (cyc_valid && conn_ok && cyc_cmd.ctrl == 16'h0014
    |=> run_state == DNFE_POSRUN && target_update && run_target == $past(cyc_cmd.target))
    else $error("positioning start not seen");
  AST_CYC_ABORT: assert property (cyc_valid && conn_ok && cyc_cmd.ctrl == 16'h0000
    |=> run_state == DNFE_IDLE) else $error("abort not seen");
  AST_CYC_MAN: assert property (cyc_valid && conn_ok && cyc_cmd.ctrl inside {16'h0011, 16'h0012}
    |=> run_state == DNFE_MANRUN) else $error("manual run not seen");
  AST_NO_CONN: assert property (cyc_valid && !cyc_conn_active && conn_hist_ff == 3'h0
    && !psel && !$past(psel) && !$past(psel, 2) |=> $stable(run_state))
    else $error("frame acted without connection");
  AST_LINK_OFF: assert property (!link_up[0] [*5] |->
    !port_link_led[0] && !port_activity_indicator[0]) else $error("port leds lit without link");
  AST_LINK_IDLE: assert property ((link_up[0] && !port_traffic[0]) [*5] |->
    port_link_led[0] && !port_activity_indicator[0]) else $error("idle link shown wrongly");
  AST_MOTOR_OFF: assert property (!motor_supply_ok [*5] |-> !motor_led)
    else $error("motor led lit on bad supply");
  AST_MOTOR_ON: assert property ((motor_supply_ok && !factory_state) [*5] |-> motor_led)
    else $error("motor led dark on good supply");
  AST_CFG_WR: assert property (cfg_wr |-> ##[0:2] nv_cfg_write_pulse)
    else $error("control value not stored");
  AST_CFG_SAVE: assert property (cfg_wr && pwdata[1:0] == CC_STORED |-> ##[0:2] nv_save_pulse)
    else $error("address not saved");
  AST_MAJOR: assert property ((major_fault && !self_test) [*5] |->
    module_health_indicator.red && !module_health_indicator.green)
    else $error("major fault not shown");
  // Main scenarios reached.
  cover property (cyc_valid && conn_ok && cyc_cmd.ctrl == 16'h0014);
  cover property (nv_save_pulse);
  cover property (run_state == DNFE_MANRUN);
endmodule : dnfe_top_props

bind dnfe_top dnfe_top_props #(.NPORTS(NPORTS)) u_props (.core_clk, .sys_rst, .paddr, .psel,
  .penable, .pwrite, .pwdata, .cyc_valid, .cyc_cmd, .cyc_conn_active, .link_up, .port_traffic,
  .self_test, .major_fault, .motor_supply_ok, .factory_state, .port_link_led,
  .port_activity_indicator, .module_health_indicator, .motor_led, .nv_save_pulse,
  .nv_cfg_write_pulse, .run_state, .run_target, .target_update);

// [test_drive_network_front_end.sv]
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the drive network front end.
module test_drive_network_front_end
  import dnfe_pkg::*;
;
  logic core_clk = 1'b0, sys_rst = 1'b1, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, run_target;
  logic [6:0] addr_switch;
  logic cyc_valid, cyc_conn_active, self_test, minor_fault, major_fault, conn_timeout;
  logic dup_address, motor_supply_ok, factory_state, motor_led, nv_save_pulse;
  logic nv_cfg_write_pulse, target_update;
  logic [1:0] link_up, port_traffic, port_link_led, port_activity_indicator;
  dnfe_cmd_s cyc_cmd;
  dnfe_led_s module_health_indicator, network_health_indicator;
  dnfe_src_e ip_source;
  dnfe_run_e run_state;
  int num_errors = 0, comparisons = 0, n_save = 0, n_cfg = 0, n_upd = 0, ticks = 0;

  dnfe_top #(.ACT_HALF_CYC(4), .FLASH_HALF_CYC(8), .MOTOR_HALF_CYC(16), .NPORTS(2)) dut (.*);
  dnfe_scanner sc (.clk(core_clk), .valid(cyc_valid), .cmd(cyc_cmd), .conn(cyc_conn_active));

  always #5 core_clk = ~core_clk;
  // Pulse counters and the hang guard; the run needs a few hundred cycles.
  always @(posedge core_clk) begin
    ticks++;
    if (nv_save_pulse === 1'b1) n_save++;
    if (nv_cfg_write_pulse === 1'b1) n_cfg++;
    if (target_update === 1'b1) n_upd++;
    if (ticks == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  // ==========================================================================
  // Shared tasks.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Samples settled outputs one step after the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Power-up: switches are set while reset holds, then sampled after release.
  task automatic rst_with(input logic [6:0] sw);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    addr_switch <= sw;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(8);
  endtask : rst_with

  // ==========================================================================
  // Scenarios.
  task automatic t_src();
    logic [6:0] sw [5] = '{7'd0, 7'd99, 7'd98, 7'd1, 7'd96};
    dnfe_src_e ex [5] = '{DNFE_SRC_DHCP, DNFE_SRC_DHCP, DNFE_SRC_BOOTP, DNFE_SRC_FIXED,
                          DNFE_SRC_FIXED};
    for (int i = 0; i < 5; i++) begin
      rst_with(sw[i]);
      chk(ip_source, ex[i], "address source");
    end
    apb(1'b0, ADDR_ACT_IP, '0);
    chk(rd, FIX_IP_BASE + 32'h60, "fixed address");
    apb(1'b0, ADDR_ACT_MASK, '0);
    chk(rd, FIX_MASK, "fixed mask");
    apb(1'b0, ADDR_ACT_GW, '0);
    chk(rd, ZERO_WORD, "fixed gateway");
    $display("t_src done");
  endtask : t_src
  task automatic t_cfg();
    int k = n_cfg;
    rst_with(7'd0);
    apb(1'b1, ADDR_CFG_CTRL, 32'h1);
    tick(2);
    chk(n_cfg, k + 1, "control value stored");
    chk(ip_source, DNFE_SRC_DHCP, "source kept until power-up");
    rst_with(7'd0);
    chk(ip_source, DNFE_SRC_BOOTP, "control value one");
    apb(1'b1, ADDR_CUR_IP, 32'h0A000107);
    k = n_save;
    apb(1'b1, ADDR_CFG_CTRL, 32'h0);
    tick(2);
    chk(n_save, k + 1, "save on zero");
    apb(1'b0, ADDR_NV_IP, '0);
    chk(rd, 32'h0A000107, "saved address");
    rst_with(7'd0);
    chk(ip_source, DNFE_SRC_STORED, "control value zero");
    apb(1'b0, ADDR_ACT_IP, '0);
    chk(rd, 32'h0A000107, "stored address applied");
    rst_with(7'd97);
    chk(ip_source, DNFE_SRC_STORED, "switch 97");
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_sw97();
    int k;
    @(posedge core_clk);
    addr_switch <= 7'd20;
    tick(8);
    k = n_save;
    @(posedge core_clk);
    addr_switch <= 7'd97;
    tick(8);
    chk(n_save, k + 1, "save on move to 97");
    $display("t_sw97 done");
  endtask : t_sw97
  task automatic t_cmd();
    logic [15:0] cw [9] = '{16'h14, 16'h14, 16'h14, 16'h11, 16'h10, 16'h12, 16'h0, 16'h4, 16'h10};
    dnfe_run_e st [9] = '{DNFE_IDLE, DNFE_POSRUN, DNFE_POSRUN, DNFE_MANRUN, DNFE_IDLE,
                          DNFE_MANRUN, DNFE_IDLE, DNFE_IDLE, DNFE_POSRUN};
    int k = n_upd;
    for (int i = 0; i < 9; i++) begin
      if (i == 1) sc.link(1'b1);
      sc.send(cw[i], 32'h1000 + i);
      tick(1);
      chk(run_state, st[i], "cyclic command");
      if (st[i] == DNFE_POSRUN) chk(run_target, 32'h1000 + (i == 8 ? 7 : i), "target");
      if (i == 1) chk(n_upd, k + 1, "target strobe");
    end
    sc.send(16'h0, '0);
    apb(1'b1, ADDR_EXP_TGT, 32'h444);
    apb(1'b1, ADDR_EXP_CTRL, 32'h10);
    tick(1);
    chk(run_state, DNFE_IDLE, "explicit refused");
    sc.link(1'b0);
    apb(1'b1, ADDR_EXP_TGT, 32'h555);
    apb(1'b1, ADDR_EXP_CTRL, 32'h10);
    tick(1);
    chk(run_state, DNFE_POSRUN, "explicit start");
    chk(run_target, 32'h555, "explicit target");
    apb(1'b1, ADDR_EXP_TGT, 32'h666);
    apb(1'b1, ADDR_EXP_CTRL, 32'h0);
    tick(1);
    chk(run_state, DNFE_IDLE, "explicit abort");
    apb(1'b1, ADDR_EXP_CTRL, 32'h10);
    tick(1);
    chk({run_target[29:0], run_state}, {30'h666, DNFE_POSRUN}, "release later");
    $display("t_cmd done");
  endtask : t_cmd
  task automatic t_led();
    int tg = 0;
    logic p;
    @(posedge core_clk);
    link_up <= 2'b00;
    tick(6);
    chk({port_link_led, port_activity_indicator}, 4'h0, "no link");
    @(posedge core_clk);
    link_up <= 2'b11;
    tick(6);
    chk({port_link_led, port_activity_indicator}, 4'hC, "idle link");
    @(posedge core_clk);
    port_traffic <= 2'b11;
    for (int i = 0; i < 24; i++) begin
      p = port_activity_indicator[0];
      tick(1);
      if (port_activity_indicator[0] !== p) tg++;
    end
    chk(tg >= 4, 1'b1, "activity flicker");
    @(posedge core_clk);
    {motor_supply_ok, major_fault} <= 2'b01;
    tick(6);
    chk({motor_led, module_health_indicator}, 3'b010, "supply bad, major fault");
    @(posedge core_clk);
    {motor_supply_ok, factory_state, major_fault, dup_address} <= 4'b1101;
    tick(6);
    chk(network_health_indicator, 2'b10, "duplicate address");
    tg = 0;
    for (int i = 0; i < 40; i++) begin
      p = motor_led;
      tick(1);
      if (motor_led !== p) tg++;
    end
    chk(tg >= 2, 1'b1, "factory flashing");
    @(posedge core_clk);
    {dup_address, conn_timeout, minor_fault} <= 3'b011;
    tick(6);
    tg = 0;
    for (int i = 0; i < 16; i++) begin
      tick(1);
      tg += (module_health_indicator === 2'b10) + 32 * (network_health_indicator === 2'b10);
    end
    chk(tg, 264, "fault flashing");
    apb(1'b0, 8'h40, '0);
    chk({er, rd[30:0]}, {1'b1, 31'h0}, "unmapped read");
    $display("t_led done");
  endtask : t_led

  // Main sequence: every input has a value at time zero.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, addr_switch} = '0;
    {link_up, port_traffic, self_test, minor_fault, major_fault, conn_timeout} = '0;
    {dup_address, motor_supply_ok, factory_state} = 3'b010;
    t_src();
    t_cfg();
    t_sw97();
    t_cmd();
    t_led();
    stop_test();
  end
endmodule : test_drive_network_front_end
